// >>> rtl/vfd_format_out.sv
// format-detect reporting, candidate limiting and output code formatting with vbi slicing
// assumes an i2c core giving sub-address strobes and a 4:2:2 sample stream on the 27 MHz clock
// Operation
// - auto detection stores line count, subcarrier, encoding and mono in the status register
// - ntsc m/j and the pal b/d/g/h/i/n group each report one shared result
// - monochrome is only reported while colour kill is on
// - in auto mode each set limit bit removes one format from the candidates
// - default blanking is lines 1-19, 263.5-282.5 or 623.5-23.5, 311-335
// - blanking codes 001-011 extend and 111-101 shorten the end by 1-3 lines
// - processed codes stay within 1 to 254 unless clipping is off with timing references suppressed
// - with clipping on, luma is 16-235 and chroma 16-240, else 1-254 while timing references are not suppressed
// - clipping off with timing references suppressed allows codes 0 to 255
// - v flag select 0 gives v on 525 lines 1-9, 264-272 and 625 lines 1-22
// - v flag select 1 gives 525 lines 1-19, 264-282 and 625 lines 311-335, 624-625
// - v flag ranges never follow the blanking length setting
// - luma is sliced during blanking and paired chroma takes the same level
// - threshold select gives 25 ire when 0 and 50 ire when 1
// - samples above threshold output the high slice value, default 235
// - samples at or below threshold output the low slice value, default 16
// - slice conversion applies to either the cb/y or the cr/y pairing
// - auto enable chooses manual formats at 0 and automatic detection at 1
module vfd_format_out import vfd_pkg::*; #(
	parameter int LINE_W = 10,
	parameter bit SLICE_PAIR_CR = 1'b0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic auto_format_detect_en,
	input wire logic color_kill_en,
	input wire logic timing_ref_suppress,
	input wire logic det_valid,
	input wire logic detected_line_count,
	input wire logic [1:0] detected_subcarrier,
	input wire logic [1:0] detected_color_encoding,
	input wire logic det_monochrome,
	input wire logic detection_undetermined,
	output logic [NUM_CAND-1:0] candidate_permit,
	input wire logic in_valid,
	input wire logic [7:0] in_code,
	input wire logic in_is_luma,
	input wire logic in_is_cr,
	input wire logic in_trs,
	input wire logic [LINE_W-1:0] in_line,
	input wire logic in_second_half,
	input wire logic in_is_625,
	output logic out_valid,
	output logic [7:0] out_code,
	output logic out_is_luma,
	output logic out_vflag,
	output logic out_sliced
);
	if (LINE_W < 10) begin : g_bad_width
		$error("line counter too narrow for 625 lines");
	end

	logic rst_meta;
	logic rst_n;
	logic [7:0] detect_candidate_limits;
	logic [7:0] vbi_and_output_code_control;
	logic [7:0] slice_high_value;
	logic [7:0] slice_low_value;
	logic [7:0] input_video_status;
	logic [2:0] blanking_length_sel;
	logic output_code_clip_en;
	logic vflag_range_sel;
	logic slice_threshold_sel;
	logic cur_vblank;
	logic cur_vflag;
	logic s1_valid;
	logic [7:0] s1_code;
	logic s1_is_luma;
	logic s1_is_cr;
	logic s1_trs;
	logic s1_vblank;
	logic s1_vflag;
	logic [7:0] threshold;
	logic s1_paired;
	logic [7:0] code_lo;
	logic [7:0] code_hi;
	logic [7:0] next_code;
	logic next_sliced;

	// two-stage reset release
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	assign blanking_length_sel = vbi_and_output_code_control[CT_BLANK_LSB +: 3];
	assign output_code_clip_en = vbi_and_output_code_control[CT_CLIP];
	assign vflag_range_sel = vbi_and_output_code_control[CT_VSEL];
	assign slice_threshold_sel = vbi_and_output_code_control[CT_SLICE_THRESHOLD_SEL];

	// writable registers; the status address has no write path at all
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			detect_candidate_limits <= CAND_RST;
			vbi_and_output_code_control <= CTRL_RST;
			slice_high_value <= SLICE_HI_RST;
			slice_low_value <= SLICE_LO_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				REG_CAND: detect_candidate_limits <= reg_wdata & CAND_USED_MASK;
				REG_CTRL: vbi_and_output_code_control <= reg_wdata;
				REG_SLICE_HI: slice_high_value <= reg_wdata;
				REG_SLICE_LO: slice_low_value <= reg_wdata;
				default: ;
			endcase
		end
	end

	// registered read data, unmapped addresses read zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CAND: reg_rdata <= detect_candidate_limits;
				REG_CTRL: reg_rdata <= vbi_and_output_code_control;
				REG_SLICE_HI: reg_rdata <= slice_high_value;
				REG_SLICE_LO: reg_rdata <= slice_low_value;
				REG_STATUS: reg_rdata <= input_video_status;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// detection status; the detector's codes already merge ntsc m/j and the pal group,
	// so the register keeps no finer distinction than those shared codes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_video_status <= STATUS_RST;
		end else if (auto_format_detect_en && det_valid) begin
			input_video_status[ST_SCF_LSB +: 2] <= detected_subcarrier;
			input_video_status[ST_ENC_LSB +: 2] <= detected_color_encoding;
			input_video_status[DETECTED_LINE_COUNT] <= detected_line_count;
			input_video_status[ST_MONO] <= det_monochrome && color_kill_en;
			input_video_status[ST_UNDET] <= detection_undetermined;
			input_video_status[ST_LOCKED] <= !detection_undetermined;
		end
	end

	// candidate permits; the host keeps incompatible pairs apart and only changes
	// limits with auto off, so no interlock is built here
	localparam int CAND_POS [NUM_CAND] = '{CB_PAL_M, CB_PAL_NC, CB_SECAM, CB_NTSC_443, CB_PAL_60,
		CB_525_LINE, CB_625_LINE};
	for (genvar gi = 0; gi < NUM_CAND; gi++) begin : g_permit
		assign candidate_permit[gi] = !auto_format_detect_en || !detect_candidate_limits[CAND_POS[gi]];
	end

	vfd_line_timing #(
		.LINE_W(LINE_W)
	) u_timing (
		.line_num(in_line),
		.second_half(in_second_half),
		.is_625(in_is_625),
		.blanking_length_sel(blanking_length_sel),
		.vflag_range_sel(vflag_range_sel),
		.vblank(cur_vblank),
		.vflag(cur_vflag)
	);

	// one-sample hold so a chroma word can see the luma word that follows it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_valid <= 1'b0;
			s1_code <= 8'h00;
			s1_is_luma <= 1'b0;
			s1_is_cr <= 1'b0;
			s1_trs <= 1'b0;
			s1_vblank <= 1'b0;
			s1_vflag <= 1'b0;
		end else if (in_valid) begin
			s1_valid <= 1'b1;
			s1_code <= in_code;
			s1_is_luma <= in_is_luma;
			s1_is_cr <= in_is_cr;
			s1_trs <= in_trs;
			s1_vblank <= cur_vblank;
			s1_vflag <= cur_vflag;
		end
	end

	assign threshold = slice_threshold_sel ? SLICE_TH_50 : SLICE_TH_25;
	assign s1_paired = !s1_is_luma && (s1_is_cr == SLICE_PAIR_CR);

	// code limits by mode
	always_comb begin
		if (output_code_clip_en) begin
			code_lo = CLIP_LO;
			code_hi = s1_is_luma ? CLIP_LUMA_HI : CLIP_CHROMA_HI;
		end else if (timing_ref_suppress) begin
			code_lo = CODE_FULL_MIN;
			code_hi = CODE_FULL_MAX;
		end else begin
			code_lo = CODE_MIN;
			code_hi = CODE_MAX;
		end
	end

	// output value: timing words pass, blank luma and its paired chroma slice, the rest clip
	always_comb begin
		next_sliced = 1'b0;
		if (s1_trs) begin
			next_code = s1_code;
		end else if (s1_vblank && s1_is_luma) begin
			next_sliced = 1'b1;
			next_code = (s1_code > threshold) ? slice_high_value : slice_low_value;
		end else if (s1_vblank && s1_paired && in_is_luma && !in_trs) begin
			next_sliced = 1'b1;
			next_code = (in_code > threshold) ? slice_high_value : slice_low_value;
		end else if (s1_code < code_lo) begin
			next_code = code_lo;
		end else if (s1_code > code_hi) begin
			next_code = code_hi;
		end else begin
			next_code = s1_code;
		end
	end

	// output register; a held sample leaves only when the next one arrives
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_code <= 8'h00;
			out_is_luma <= 1'b0;
			out_vflag <= 1'b0;
			out_sliced <= 1'b0;
		end else begin
			out_valid <= in_valid && s1_valid;
			if (in_valid && s1_valid) begin
				out_code <= next_code;
				out_is_luma <= s1_is_luma;
				out_vflag <= s1_vflag;
				out_sliced <= next_sliced;
			end
		end
	end

	// checks
	a_status_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
		auto_format_detect_en && det_valid |=> input_video_status[ST_ENC_LSB +: 2] == $past(detected_color_encoding)
		&& input_video_status[ST_SCF_LSB +: 2] == $past(detected_subcarrier)
		&& input_video_status[DETECTED_LINE_COUNT] == $past(detected_line_count))
		else $error("status not updated from detection");

	a_status_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!(auto_format_detect_en && det_valid) |=> $stable(input_video_status))
		else $error("status changed without detection");

	a_mono_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		auto_format_detect_en && det_valid && !color_kill_en |=> !input_video_status[ST_MONO])
		else $error("mono reported with colour kill off");

	a_status_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
		auto_format_detect_en && det_valid
		|=> input_video_status[ST_LOCKED] == !$past(detection_undetermined)
		&& input_video_status[ST_UNDET] == $past(detection_undetermined))
		else $error("lock state not reported");
	a_permit_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
		auto_format_detect_en |-> candidate_permit[3] == !detect_candidate_limits[CB_NTSC_443]
		&& candidate_permit[5] == !detect_candidate_limits[CB_525_LINE])
		else $error("candidate permit wrong");

	a_permit_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!auto_format_detect_en
		|-> &candidate_permit)
		else $error("format excluded with auto off");

	// blanking window and v flag edges, straight from the line decode
	a_blank_default: assert property (@(posedge ref_clk) disable iff (!rst_n)
		blanking_length_sel == 3'b000 && !in_is_625 |-> (in_line == LINE_W'(19) ? cur_vblank : 1'b1)
		&& (in_line == LINE_W'(20) ? !cur_vblank : 1'b1))
		else $error("default 525 blanking edge wrong");

	a_blank_extend: assert property (@(posedge ref_clk) disable iff (!rst_n)
		blanking_length_sel == 3'b011 && !in_is_625 && in_line == LINE_W'(22) |-> cur_vblank)
		else $error("blanking not extended");

	a_blank_shorten: assert property (@(posedge ref_clk) disable iff (!rst_n)
		blanking_length_sel == 3'b101 && !in_is_625
		&& in_line == LINE_W'(17) |-> !cur_vblank)
		else $error("blanking not shortened");
	a_vflag_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!vflag_range_sel && !in_is_625 && in_line == LINE_W'(10) |-> !cur_vflag)
		else $error("v flag set on line 10");

	a_vflag_tail: assert property (@(posedge ref_clk) disable iff (!rst_n)
		vflag_range_sel && in_is_625 && in_line == LINE_W'(624) |-> cur_vflag)
		else $error("v flag clear on line 624");

	a_vflag_long: assert property (@(posedge ref_clk) disable iff (!rst_n)
		vflag_range_sel && !in_is_625
		&& in_line == LINE_W'(282) |-> cur_vflag)
		else $error("v flag clear on line 282");

	// output codes, judged against the settings in force when the code was formed
	a_clip_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
		out_valid && $past(output_code_clip_en) && out_is_luma && !out_sliced && !$past(s1_trs)
		|-> out_code >= CLIP_LO && out_code <= CLIP_LUMA_HI)
		else $error("luma outside clip range");

	a_clip_chroma: assert property (@(posedge ref_clk) disable iff (!rst_n)
		out_valid && $past(output_code_clip_en) && !out_is_luma && !out_sliced && !$past(s1_trs)
		|-> out_code >= CLIP_LO && out_code <= CLIP_CHROMA_HI)
		else $error("chroma outside clip range");
	a_code_span: assert property (@(posedge ref_clk) disable iff (!rst_n)
		out_valid && !out_sliced && !$past(s1_trs) && !$past(output_code_clip_en) && !$past(timing_ref_suppress)
		|-> out_code >= CODE_MIN && out_code <= CODE_MAX)
		else $error("code outside 1 to 254");

	a_slice_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
		in_valid && s1_valid && s1_vblank && s1_is_luma && !s1_trs && !slice_threshold_sel && s1_code == 8'h48
		|=> out_code == $past(slice_high_value))
		else $error("slice above 25 ire not high");

	a_slice_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		in_valid && s1_valid && s1_vblank && s1_is_luma && !s1_trs && s1_code == threshold
		|=> out_code == $past(slice_low_value))
		else $error("slice at threshold not low");

	a_chroma_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
		in_valid && s1_valid && s1_vblank && s1_paired && !s1_trs && in_is_luma && !in_trs
		|=> out_sliced && !out_is_luma)
		else $error("paired chroma not sliced");

	a_slice_levels: assert property (@(posedge ref_clk) disable iff (!rst_n)
		out_valid && out_sliced |-> out_code == $past(slice_high_value) || out_code == $past(slice_low_value))
		else $error("sliced code not a slice value");

	c_slice_chroma: cover property (@(posedge ref_clk) disable iff (!rst_n) out_valid && out_sliced && !out_is_luma);
	c_clip_hit: cover property (@(posedge ref_clk) disable iff (!rst_n) out_valid && out_code == CLIP_LUMA_HI);
	c_full_span: cover property (@(posedge ref_clk) disable iff (!rst_n) out_valid && out_code == CODE_FULL_MIN);
	c_auto_update: cover property (@(posedge ref_clk) disable iff (!rst_n) auto_format_detect_en && det_valid);
	c_reserved_code: cover property (@(posedge ref_clk) disable iff (!rst_n) blanking_length_sel == 3'b100 && cur_vblank);
endmodule // vfd_format_out

// >>> rtl/vfd_line_timing.sv
// line timing decode: vertical blanking window and timing-reference v flag
// assumes line numbers count from 1 and the half-line flag marks the second half of a line
module vfd_line_timing import vfd_pkg::*; #(
	parameter int LINE_W = 10
) (
	input wire logic [LINE_W-1:0] line_num,
	input wire logic second_half,
	input wire logic is_625,
	input wire logic [2:0] blanking_length_sel,
	input wire logic vflag_range_sel,
	output logic vblank,
	output logic vflag
);
	logic signed [3:0] delta;
	logic [LINE_W-1:0] f1_end;
	logic [LINE_W-1:0] f2_end;

	// signed trim of the blanking end, reserved code 100 keeps the default
	always_comb begin
		unique case (blanking_length_sel)
			3'b001: delta = 4'sd1;
			3'b010: delta = 4'sd2;
			3'b011: delta = 4'sd3;
			3'b111: delta = -4'sd1;
			3'b110: delta = -4'sd2;
			3'b101: delta = -4'sd3;
			default: delta = 4'sd0;
		endcase
	end

	// only the interval end moves, the start stays put
	assign f1_end = LINE_W'((is_625 ? VB625_F1_END : VB525_F1_END) + int'(delta));
	assign f2_end = LINE_W'((is_625 ? VB625_F2_END : VB525_F2_END) + int'(delta));

	// blanking window with half-line edges
	always_comb begin
		if (!is_625) begin
			vblank = (line_num >= LINE_W'(1) && line_num <= f1_end) ||
				(line_num == LINE_W'(VB525_F2_HALF) && second_half) ||
				(line_num > LINE_W'(VB525_F2_HALF) && line_num <= f2_end) ||
				(line_num == f2_end + LINE_W'(1) && !second_half);
		end else begin
			vblank = (line_num == LINE_W'(VB625_F1_HALF) && second_half) ||
				(line_num > LINE_W'(VB625_F1_HALF)) ||
				(line_num >= LINE_W'(1) && line_num <= f1_end) ||
				(line_num == f1_end + LINE_W'(1) && !second_half) ||
				(line_num >= LINE_W'(VB625_F2_START) && line_num <= f2_end);
		end
	end

	// v flag ignores the blanking trim entirely
	always_comb begin
		if (!vflag_range_sel) begin
			if (!is_625) begin
				vflag = (line_num >= LINE_W'(1) && line_num <= LINE_W'(V3_525_F1_END)) ||
					(line_num >= LINE_W'(V3_525_F2_START) && line_num <= LINE_W'(V3_525_F2_END));
			end else begin
				vflag = line_num >= LINE_W'(1) && line_num <= LINE_W'(V3_625_END);
			end
		end else begin
			if (!is_625) begin
				vflag = (line_num >= LINE_W'(1) && line_num <= LINE_W'(V4_525_F1_END)) ||
					(line_num >= LINE_W'(V4_525_F2_START) && line_num <= LINE_W'(V4_525_F2_END));
			end else begin
				vflag = (line_num >= LINE_W'(V4_625_F2_START) && line_num <= LINE_W'(V4_625_F2_END)) ||
					(line_num >= LINE_W'(V4_625_F1_START));
			end
		end
	end
endmodule // vfd_line_timing

// >>> rtl/vfd_pkg.sv
// package of register offsets, field positions, reset values and code limits
// assumes one 27 MHz decoder clock domain and an external i2c core giving sub-address accesses
package vfd_pkg;
	// register sub-addresses
	localparam logic [7:0] REG_CAND = 8'h03;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_SLICE_HI = 8'h11;
	localparam logic [7:0] REG_SLICE_LO = 8'h12;
	localparam logic [7:0] REG_STATUS = 8'h18;
	// reset values
	localparam logic [7:0] CAND_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] SLICE_HI_RST = 8'hEB;
	localparam logic [7:0] SLICE_LO_RST = 8'h10;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CAND_USED_MASK = 8'hF7;
	// candidate-limit bit positions, bit 3 reserved
	localparam int CB_PAL_M = 0;
	localparam int CB_PAL_NC = 1;
	localparam int CB_SECAM = 2;
	localparam int CB_NTSC_443 = 4;
	localparam int CB_PAL_60 = 5;
	localparam int CB_525_LINE = 6;
	localparam int CB_625_LINE = 7;
	localparam int NUM_CAND = 7;
	// control register fields
	localparam int CT_BLANK_LSB = 0;
	localparam int CT_CLIP = 3;
	localparam int CT_VSEL = 4;
	localparam int CT_SLICE_THRESHOLD_SEL = 5;
	// status register fields
	localparam int ST_SCF_LSB = 0;
	localparam int ST_ENC_LSB = 2;
	localparam int DETECTED_LINE_COUNT = 4;
	localparam int ST_MONO = 5;
	localparam int ST_UNDET = 6;
	localparam int ST_LOCKED = 7;
	// output code limits
	localparam logic [7:0] CODE_MIN = 8'h01;
	localparam logic [7:0] CODE_MAX = 8'hFE;
	localparam logic [7:0] CODE_FULL_MIN = 8'h00;
	localparam logic [7:0] CODE_FULL_MAX = 8'hFF;
	localparam logic [7:0] CLIP_LO = 8'h10;
	localparam logic [7:0] CLIP_LUMA_HI = 8'hEB;
	localparam logic [7:0] CLIP_CHROMA_HI = 8'hF0;
	// slice thresholds: 25 and 50 IRE above black on a 219-code luma swing
	localparam logic [7:0] SLICE_TH_25 = 8'h47;
	localparam logic [7:0] SLICE_TH_50 = 8'h7E;
	// line numbers of the default blanking interval
	localparam int VB525_F1_END = 19;
	localparam int VB525_F2_HALF = 263;
	localparam int VB525_F2_END = 282;
	localparam int VB625_F1_HALF = 623;
	localparam int VB625_F1_END = 23;
	localparam int VB625_F2_START = 311;
	localparam int VB625_F2_END = 335;
	// v flag line ranges
	localparam int V3_525_F1_END = 9;
	localparam int V3_525_F2_START = 264;
	localparam int V3_525_F2_END = 272;
	localparam int V3_625_END = 22;
	localparam int V4_525_F1_END = 19;
	localparam int V4_525_F2_START = 264;
	localparam int V4_525_F2_END = 282;
	localparam int V4_625_F2_START = 311;
	localparam int V4_625_F2_END = 335;
	localparam int V4_625_F1_START = 624;
endpackage : vfd_pkg

// >>> test/tb_video_format_detect_vbi_output.sv
// self-checking bench for the format reporting and output formatting block
// assumes the receiver model logs samples in order; expectations come from bench functions
module tb_video_format_detect_vbi_output import vfd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, det_valid = 1'b0;
	logic auto_format_detect_en = 1'b0, color_kill_en = 1'b0, timing_ref_suppress = 1'b0;
	logic detected_line_count = 1'b0, det_monochrome = 1'b0, detection_undetermined = 1'b0;
	logic [1:0] detected_subcarrier = 2'h0, detected_color_encoding = 2'h0, enc;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, in_code = 8'h00, out_code;
	logic in_valid = 1'b0, in_is_luma = 1'b0, in_is_cr = 1'b0, in_trs = 1'b0;
	logic in_second_half = 1'b0, in_is_625 = 1'b0, f6 = 1'b0;
	logic [9:0] in_line = 10'h001;
	logic [6:0] candidate_permit;
	logic out_valid, out_is_luma, out_vflag, out_sliced;
	logic [7:0] ctl = CTRL_RST, shi = SLICE_HI_RST, slo = SLICE_LO_RST, st = STATUS_RST, v;
	logic [12:0] exq[$];
	logic [7:0] cor[16] = '{8'h47, 8'h48, 8'h7E, 8'h7F, 8'h00, 8'hFF, 8'h01, 8'hFE,
		8'h0F, 8'h10, 8'hEB, 8'hEC, 8'hF0, 8'hF1, 8'h80, 8'h46};
	int seed = 68748, miscompares = 0, checked = 0, cyc = 0;

	vfd_format_out #(.LINE_W(10), .SLICE_PAIR_CR(1'b0)) i_dut (.ref_clk, .nrst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .auto_format_detect_en, .color_kill_en, .timing_ref_suppress,
		.det_valid, .detected_line_count, .detected_subcarrier, .detected_color_encoding, .det_monochrome,
		.detection_undetermined, .candidate_permit, .in_valid, .in_code, .in_is_luma, .in_is_cr, .in_trs,
		.in_line, .in_second_half, .in_is_625, .out_valid, .out_code, .out_is_luma, .out_vflag, .out_sliced);
	vfd_rx_model i_rx (.ref_clk, .out_valid, .out_code, .out_vflag, .out_is_luma, .out_sliced);

	// free-running clock
	always #5 ref_clk = ~ref_clk;

	// hang guard, well above the roughly 9k cycles the run needs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		if (miscompares == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", n, e, g);
			miscompares++;
		end
	endtask

	// one-cycle write strobe; mirrors the settings the expectations depend on
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		if (a == REG_CTRL) ctl = d;
		if (a == REG_SLICE_HI) shi = d;
		if (a == REG_SLICE_LO) slo = d;
	endtask

	// read data is registered at the strobe edge and held, so sample mid-cycle
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk($sformatf("reg %h", a), e, reg_rdata);
	endtask

	// slice values must avoid the timing reference codes
	function automatic logic [7:0] nz();
		logic [7:0] r;
		r = $random(seed);
		return (r == 8'h00 || r == 8'hFF) ? 8'h5A : r;
	endfunction

	function automatic int dlt(input logic [2:0] s);
		if (s == 3'h4) return 0;
		return s[2] ? int'(s) - 8 : int'(s);
	endfunction

	// 1 blanked, 0 active, 2 half-line edge left unchecked
	function automatic int blk(input int ln);
		int e;
		e = dlt(ctl[2:0]);
		if (!f6) begin
			if (ln == VB525_F2_HALF || ln == VB525_F2_END + e + 1) return 2;
			return int'(ln <= VB525_F1_END + e || (ln > VB525_F2_HALF && ln <= VB525_F2_END + e));
		end
		if (ln == VB625_F1_HALF || ln == VB625_F1_END + e + 1) return 2;
		return int'(ln > VB625_F1_HALF || ln <= VB625_F1_END + e || (ln >= VB625_F2_START && ln <= VB625_F2_END + e));
	endfunction

	function automatic logic vf(input int ln);
		if (!ctl[CT_VSEL]) return f6 ? ln <= V3_625_END : (ln <= V3_525_F1_END || (ln >= V3_525_F2_START && ln <= V3_525_F2_END));
		return f6 ? ((ln >= V4_625_F2_START && ln <= V4_625_F2_END) || ln >= V4_625_F1_START) :
			(ln <= V4_525_F1_END || (ln >= V4_525_F2_START && ln <= V4_525_F2_END));
	endfunction

	function automatic logic [7:0] clp(input logic [7:0] c, input logic y);
		logic [7:0] lo, hi;
		if (ctl[CT_CLIP]) begin
			lo = CLIP_LO;
			hi = y ? CLIP_LUMA_HI : CLIP_CHROMA_HI;
		end else if (timing_ref_suppress) begin
			lo = CODE_FULL_MIN;
			hi = CODE_FULL_MAX;
		end else begin
			lo = CODE_MIN;
			hi = CODE_MAX;
		end
		return c < lo ? lo : (c > hi ? hi : c);
	endfunction

	function automatic logic [7:0] sl(input logic [7:0] c);
		return c > (ctl[CT_SLICE_THRESHOLD_SEL] ? SLICE_TH_50 : SLICE_TH_25) ? shi : slo;
	endfunction

	// k is {trs, cr, luma}; m bit0 checks the code, bit1 the v flag
	task automatic smp(input logic [7:0] c, input logic [2:0] k, input int ln, input logic h,
		input logic [1:0] m, input logic [7:0] e);
		@(posedge ref_clk);
		in_valid <= 1'b1;
		in_code <= c;
		{in_trs, in_is_cr, in_is_luma} <= k;
		in_line <= 10'(ln);
		in_second_half <= h;
		in_is_625 <= f6;
		exq.push_back({blk(ln) == 1 && k[2:1] == 2'h0, k[0], m, vf(ln), e});
	endtask

	// one cb y cr y quad on a line, codes mixing corners and random values
	task automatic grp(input int ln);
		logic [7:0] c[4];
		int b;
		logic h;
		logic [1:0] m;
		h = $random(seed);
		b = blk(ln);
		m = (b == 2) ? 2'h2 : 2'h3;
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			c[i] = v[0] ? cor[v[7:4]] : v;
		end
		smp(c[0], 3'h0, ln, h, m, b == 1 ? sl(c[1]) : clp(c[0], 1'b0));
		smp(c[1], 3'h1, ln, h, m, b == 1 ? sl(c[1]) : clp(c[1], 1'b1));
		smp(c[2], 3'h2, ln, h, m, clp(c[2], 1'b0));
		smp(c[3], 3'h1, ln, h, m, b == 1 ? sl(c[3]) : clp(c[3], 1'b1));
	endtask

	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rchk(REG_CAND, CAND_RST);
		rchk(REG_CTRL, CTRL_RST);
		rchk(REG_SLICE_HI, SLICE_HI_RST);
		rchk(REG_SLICE_LO, SLICE_LO_RST);
		rchk(REG_STATUS, STATUS_RST);
		wr(8'h05, 8'hA5);
		wr(REG_CTRL, 8'hC0);
		rchk(8'h05, 8'h00);
		rchk(REG_CTRL, 8'hC0);
		@(negedge ref_clk);
		chk("permit off", 8'h7F, {1'b0, candidate_permit});
		// single exclusions first, then legal random sets, each by the documented sequence
		for (int i = 0; i < 12; i++) begin
			v = (i < 8) ? 8'h01 << i : 8'($random(seed));
			if (v[4] & v[5]) v[5] = 1'b0;
			if (v[6] & v[7]) v[7] = 1'b0;
			@(posedge ref_clk);
			auto_format_detect_en <= 1'b0;
			wr(REG_CAND, CAND_RST);
			wr(REG_CAND, v);
			auto_format_detect_en <= 1'b1;
			@(negedge ref_clk);
			chk("permit", {1'b0, ~v[7:4], ~v[2:0]}, {1'b0, candidate_permit});
			rchk(REG_CAND, v & CAND_USED_MASK);
		end
		// detector results with auto on and off, colour kill on and off
		for (int i = 0; i < 12; i++) begin
			v = $random(seed);
			v[7] = v[7] | (i == 0);
			enc = (v[2:1] == 2'h3) ? 2'h1 : v[2:1];
			@(posedge ref_clk);
			auto_format_detect_en <= v[7];
			color_kill_en <= v[6];
			detection_undetermined <= v[5];
			det_monochrome <= v[4];
			detected_line_count <= v[3];
			detected_color_encoding <= enc;
			detected_subcarrier <= v[1:0];
			det_valid <= 1'b1;
			@(posedge ref_clk);
			det_valid <= 1'b0;
			if (v[7]) st = {~v[5], v[5], v[4] & v[6], v[3], enc, v[1:0]};
			rchk(REG_STATUS, st);
		end
		wr(REG_STATUS, ~st);
		rchk(REG_STATUS, st);
		// output stream: every blanking code, random settings, lines around each boundary
		for (int s = 0; s < 16; s++) begin
			smp(8'hFF, 3'h4, 1, 1'b0, 2'h1, 8'hFF);
			// strobe off while settings change, the timing word shields the held sample
			@(posedge ref_clk);
			in_valid <= 1'b0;
			v = $random(seed);
			timing_ref_suppress <= v[2];
			wr(REG_CTRL, {v[7:3], s[2:0]});
			if (s > 0) begin
				wr(REG_SLICE_HI, nz());
				wr(REG_SLICE_LO, nz());
			end
			for (int f = 0; f < 2; f++) begin
				f6 = f[0];
				for (int ln = 1; ln <= 625; ln++) begin
					if (ln <= 30 || (f == 0 && ln >= 258 && ln <= 290) || (f == 1 && ((ln >= 305 && ln <= 342) || ln >= 618)))
						grp(ln);
				end
			end
		end
		smp(8'hFF, 3'h4, 1, 1'b0, 2'h0, 8'hFF);
		@(posedge ref_clk);
		in_valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("count", 8'(exq.size() - 1), 8'(i_rx.got.size()));
		for (int i = 0; i < i_rx.got.size() && i < exq.size(); i++) begin
			if (exq[i][9]) chk("code", exq[i][7:0], i_rx.got[i][7:0]);
			if (exq[i][10]) chk("vflag", {7'h00, exq[i][8]}, {7'h00, i_rx.got[i][8]});
			chk("luma", {7'h00, exq[i][11]}, {7'h00, i_rx.got[i][9]});
			if (exq[i][9]) chk("sliced", {7'h00, exq[i][12]}, {7'h00, i_rx.got[i][10]});
		end
		conclude();
	end
endmodule // tb_video_format_detect_vbi_output

// >>> test/vfd_rx_model.sv
// video receiver model: logs every output sample strobe with its v flag
// assumes out_* are registered on the rising edge of ref_clk
module vfd_rx_model (
	input wire logic ref_clk,
	input wire logic out_valid,
	input wire logic [7:0] out_code,
	input wire logic out_vflag,
	input wire logic out_is_luma,
	input wire logic out_sliced
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [10:0] got[$];

	// capture on the strobe only; data between strobes is stale
	always @(posedge ref_clk) begin
		if (out_valid === 1'b1) got.push_back({out_sliced, out_is_luma, out_vflag, out_code});
	end
endmodule // vfd_rx_model
